// [src/ebdt_pkg.sv]
// package for the eight-bit demodulating timer: offsets, fields, reset values
package ebdt_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL_FIRST   = 8'h00;
    localparam logic [7:0] OFS_CTRL_SECOND  = 8'h04;
    localparam logic [7:0] OFS_INIT_LOW     = 8'h08;
    localparam logic [7:0] OFS_INIT_HIGH    = 8'h0c;
    localparam logic [7:0] OFS_POS_CAPTURE  = 8'h10;
    localparam logic [7:0] OFS_NEG_CAPTURE  = 8'h14;
    localparam logic [7:0] OFS_COUNTER      = 8'h18;
    localparam logic [7:0] OFS_IRQ_STATUS   = 8'h1c;
    localparam logic [7:0] OFS_IRQ_MASK     = 8'h20;
    // first control register fields
    localparam int CF_ENABLE     = 7;
    localparam int CF_SINGLE     = 6;
    localparam int CF_TIMEOUT    = 5;
    localparam int CF_CLKSEL_HI  = 4;
    localparam int CF_CLKSEL_LO  = 3;
    localparam int CF_CAP_IE     = 2;
    localparam int CF_TO_IE      = 1;
    // second control register fields
    localparam int CS_DEMOD      = 6;
    localparam int CS_EDGE_HI    = 5;
    localparam int CS_EDGE_LO    = 4;
    localparam int CS_POS_FLAG   = 1;
    localparam int CS_NEG_FLAG   = 0;
    // edge select codes
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;
    // interrupt status bits
    localparam int IRQ_TIMEOUT = 0;
    localparam int IRQ_CAPTURE = 1;
    // reset values and demodulation reload value
    localparam logic [7:0] RST_CTRL  = 8'h00;
    localparam logic [7:0] RST_INIT  = 8'hff;
    localparam logic [7:0] DEMOD_RELOAD = 8'hff;
    // counter clock dividers, in system clocks
    localparam int DIV_SEL0 = 2;
    localparam int DIV_SEL1 = 4;
    localparam int DIV_SEL2 = 8;
    localparam int DIV_SEL3 = 16;
    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// [src/ebdt_clkdiv.sv]
// counter tick divider: one-cycle enable pulse every selected number of clocks
`timescale 1ns/1ps
`default_nettype none
module ebdt_clkdiv (
    input  wire logic       mclk_i,
    input  wire logic       reset_i,
    input  wire logic       run_i,
    input  wire logic [1:0] sel_i,
    output logic            tick_o
);
    logic [3:0] cnt;
    wire  [3:0] top_w = (sel_i == 2'h0) ? 4'(ebdt_pkg::DIV_SEL0 - 1) :
                        (sel_i == 2'h1) ? 4'(ebdt_pkg::DIV_SEL1 - 1) :
                        (sel_i == 2'h2) ? 4'(ebdt_pkg::DIV_SEL2 - 1) :
                                          4'(ebdt_pkg::DIV_SEL3 - 1);

    always_ff @(posedge mclk_i) begin
        if (reset_i || !run_i || cnt >= top_w) begin
            cnt <= 4'h0;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end

    assign tick_o = run_i && (cnt >= top_w);
endmodule // ebdt_clkdiv
`default_nettype wire

// [src/ebdt_timer.sv]
// eight-bit down-counter with modulo/single mode and edge demodulation capture
// What this block does
// RULE1 - writing 1 to enable field of first control register starts counter
// RULE2 - count mode 0: reload initial value at terminal count, keep running
// RULE3 - count mode 1: stop at terminal count
// RULE4 - time-out flag set at terminal count; cleared only by writing 1
// RULE5 - software clears time-out flag before enabling the counter
// RULE6 - software avoids read-modify-write of control registers with status bits
// RULE7 - clock select field picks rate of the counter decrement tick
// RULE8 - capture interrupt enable raises interrupt on every demodulation capture; code also requires irq_mask bit 1
// RULE9 - software loads both initial-count registers with ffh before demodulation
// RULE10 - demodulation: counting begins on first edge chosen by edge-select bits 5:4
// RULE11 - later qualifying edges capture one's complement of counter
// RULE12 - rising edge captures to positive register, falling to negative register
// RULE13 - capture sets matching edge flag bit 1 or 0; interrupt if enabled
// RULE14 - each capture reloads counter with ffh and counting continues
// RULE15 - demodulation terminal count sets time-out, may interrupt, continues from ffh
// RULE16 - capture input synchronised before edge detection, one event per transition
`timescale 1ns/1ps
`default_nettype none
module ebdt_timer (
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        capture_pin_i,
    output logic             irq_o
);
    // =====================================================================
    // registers and state
    // =====================================================================
    logic [7:0] ctrl_first;
    logic [7:0] ctrl_second;
    logic [7:0] init_low;
    logic [7:0] init_high;
    logic [7:0] pos_capture;
    logic [7:0] neg_capture;
    logic [7:0] counter;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic       running;
    logic       armed;
    logic       phase_high;
    logic       sync_a;
    logic       sync_b;
    logic       sync_prev;
    logic [7:0] aw_addr;
    logic       aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic       w_held;

    // =====================================================================
    // bus write side
    // =====================================================================
    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire wlane0   = w_strb[0];
    wire [7:0] wb = w_data[7:0];
    wire wr_first  = do_write && wlane0 && aw_addr == ebdt_pkg::OFS_CTRL_FIRST;
    wire wr_second = do_write && wlane0 && aw_addr == ebdt_pkg::OFS_CTRL_SECOND;
    wire wr_low    = do_write && wlane0 && aw_addr == ebdt_pkg::OFS_INIT_LOW;
    wire wr_high   = do_write && wlane0 && aw_addr == ebdt_pkg::OFS_INIT_HIGH;
    wire wr_stat   = do_write && wlane0 && aw_addr == ebdt_pkg::OFS_IRQ_STATUS;
    wire wr_mask   = do_write && wlane0 && aw_addr == ebdt_pkg::OFS_IRQ_MASK;
    wire aw_hit    = aw_addr <= ebdt_pkg::OFS_IRQ_MASK && aw_addr[1:0] == 2'h0;

    assign s_axi_awready = !aw_held;
    assign s_axi_wready  = !w_held;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0;
            w_strb  <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= ebdt_pkg::AXI_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= aw_hit ? ebdt_pkg::AXI_OKAY : ebdt_pkg::AXI_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held <= 1'b0;
                w_held  <= 1'b0;
            end
        end
    end

    // =====================================================================
    // edge detection
    // =====================================================================
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            sync_a    <= 1'b0;
            sync_b    <= 1'b0;
            sync_prev <= 1'b0;
        end else begin
            sync_a    <= capture_pin_i; // [RULE16]
            sync_b    <= sync_a;
            sync_prev <= sync_b;
        end
    end

    wire       demod    = ctrl_second[ebdt_pkg::CS_DEMOD];
    wire [1:0] edge_sel = ctrl_second[ebdt_pkg::CS_EDGE_HI:ebdt_pkg::CS_EDGE_LO];
    wire rise_raw = sync_b && !sync_prev; // [RULE16]
    wire fall_raw = !sync_b && sync_prev;
    wire rise_q   = rise_raw && (edge_sel == ebdt_pkg::EDGE_RISE
                                 || edge_sel == ebdt_pkg::EDGE_BOTH); // [RULE10]
    wire fall_q   = fall_raw && (edge_sel == ebdt_pkg::EDGE_FALL
                                 || edge_sel == ebdt_pkg::EDGE_BOTH);
    wire edge_q   = rise_q || fall_q;

    // =====================================================================
    // counter core
    // =====================================================================
    wire enable    = ctrl_first[ebdt_pkg::CF_ENABLE];
    wire single    = ctrl_first[ebdt_pkg::CF_SINGLE];
    wire [1:0] csel = ctrl_first[ebdt_pkg::CF_CLKSEL_HI:ebdt_pkg::CF_CLKSEL_LO];
    wire tick;

    ebdt_clkdiv u_div (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .run_i   (running),
        .sel_i   (csel),
        .tick_o  (tick)
    ); // [RULE7]

    wire capture   = running && demod && armed && edge_q;        // [RULE11]
    wire term      = running && tick && counter == 8'h00 && !capture;
    wire cap_pos   = capture && rise_q;                          // [RULE12]
    wire cap_neg   = capture && fall_q;
    wire [7:0]  reload    = phase_high ? init_low : init_high;
    wire start     = wr_first && wb[ebdt_pkg::CF_ENABLE];

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            counter    <= 8'h00;
            running    <= 1'b0;
            armed      <= 1'b0;
            phase_high <= 1'b0;
        end else if (start) begin
            counter    <= wb[ebdt_pkg::CF_SINGLE] ? init_low : init_high; // [RULE1]
            running    <= !ctrl_second[ebdt_pkg::CS_DEMOD];
            armed      <= 1'b0;
            phase_high <= 1'b1;
        end else if (enable && demod && !running && edge_q) begin
            running <= 1'b1;                                    // [RULE10]
            armed   <= 1'b1;
            counter <= ebdt_pkg::DEMOD_RELOAD;
        end else if (capture) begin
            counter <= ebdt_pkg::DEMOD_RELOAD;                  // [RULE14]
        end else if (term) begin
            if (demod) begin
                counter <= ebdt_pkg::DEMOD_RELOAD;              // [RULE15]
            end else if (single) begin
                running <= 1'b0;                                // [RULE3]
            end else begin
                counter    <= reload;                           // [RULE2]
                phase_high <= !phase_high;
            end
        end else if (running && tick) begin
            counter <= counter - 8'h01;
        end
    end

    // =====================================================================
    // control, status and capture registers
    // =====================================================================
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ctrl_first  <= ebdt_pkg::RST_CTRL;
            ctrl_second <= ebdt_pkg::RST_CTRL;
            init_low    <= ebdt_pkg::RST_INIT;
            init_high   <= ebdt_pkg::RST_INIT;
            pos_capture <= 8'h00;
            neg_capture <= 8'h00;
            irq_mask    <= 2'h0;
            irq_status  <= 2'h0;
        end else begin
            if (wr_first) begin
                ctrl_first[7:6] <= wb[7:6];
                ctrl_first[4:0] <= wb[4:0];
            end
            // set wins over a write-one clear
            ctrl_first[ebdt_pkg::CF_TIMEOUT] <= term
                || (ctrl_first[ebdt_pkg::CF_TIMEOUT]
                    && !(wr_first && wb[ebdt_pkg::CF_TIMEOUT]));   // [RULE4]
            if (wr_second) begin
                ctrl_second[7:2] <= wb[7:2];
            end
            ctrl_second[ebdt_pkg::CS_POS_FLAG] <= cap_pos
                || (ctrl_second[ebdt_pkg::CS_POS_FLAG]
                    && !(wr_second && wb[ebdt_pkg::CS_POS_FLAG])); // [RULE13]
            ctrl_second[ebdt_pkg::CS_NEG_FLAG] <= cap_neg
                || (ctrl_second[ebdt_pkg::CS_NEG_FLAG]
                    && !(wr_second && wb[ebdt_pkg::CS_NEG_FLAG]));
            if (wr_low) begin
                init_low <= wb;
            end
            if (wr_high) begin
                init_high <= wb;
            end
            if (cap_pos) begin
                pos_capture <= ~counter;                         // [RULE11]
            end
            if (cap_neg) begin
                neg_capture <= ~counter;                         // [RULE12]
            end
            if (wr_mask) begin
                irq_mask <= wb[1:0];
            end
            irq_status[ebdt_pkg::IRQ_TIMEOUT] <= term
                || (irq_status[ebdt_pkg::IRQ_TIMEOUT]
                    && !(wr_stat && wb[ebdt_pkg::IRQ_TIMEOUT]));
            irq_status[ebdt_pkg::IRQ_CAPTURE] <= capture
                || (irq_status[ebdt_pkg::IRQ_CAPTURE]
                    && !(wr_stat && wb[ebdt_pkg::IRQ_CAPTURE]));
        end
    end

    // enables in the first control register and the mask both gate the line
    wire to_irq  = irq_status[ebdt_pkg::IRQ_TIMEOUT] && irq_mask[ebdt_pkg::IRQ_TIMEOUT]
                   && ctrl_first[ebdt_pkg::CF_TO_IE];                 // [RULE15]
    wire cap_irq = irq_status[ebdt_pkg::IRQ_CAPTURE] && irq_mask[ebdt_pkg::IRQ_CAPTURE]
                   && ctrl_first[ebdt_pkg::CF_CAP_IE];                // [RULE8] [RULE13]
    assign irq_o = to_irq || cap_irq;

    // =====================================================================
    // bus read side
    // =====================================================================
    wire [7:0] rd_mux =
        (s_axi_araddr == ebdt_pkg::OFS_CTRL_FIRST)  ? ctrl_first  :
        (s_axi_araddr == ebdt_pkg::OFS_CTRL_SECOND) ? ctrl_second :
        (s_axi_araddr == ebdt_pkg::OFS_INIT_LOW)    ? init_low    :
        (s_axi_araddr == ebdt_pkg::OFS_INIT_HIGH)   ? init_high   :
        (s_axi_araddr == ebdt_pkg::OFS_POS_CAPTURE) ? pos_capture :
        (s_axi_araddr == ebdt_pkg::OFS_NEG_CAPTURE) ? neg_capture :
        (s_axi_araddr == ebdt_pkg::OFS_COUNTER)     ? counter     :
        (s_axi_araddr == ebdt_pkg::OFS_IRQ_STATUS)  ? {6'h0, irq_status} :
        (s_axi_araddr == ebdt_pkg::OFS_IRQ_MASK)    ? {6'h0, irq_mask}   : 8'h00;
    wire ar_hit = s_axi_araddr <= ebdt_pkg::OFS_IRQ_MASK && s_axi_araddr[1:0] == 2'h0;

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= ebdt_pkg::AXI_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h0, rd_mux};
            s_axi_rresp  <= ar_hit ? ebdt_pkg::AXI_OKAY : ebdt_pkg::AXI_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // =====================================================================
    // assertions
    // =====================================================================
    property p_start;
        @(posedge mclk_i) disable iff (reset_i)
        start && !demod |=> running;
    endproperty
    a_start: assert property (p_start) else $error("counter did not start"); // [RULE1]

    property p_reload;
        @(posedge mclk_i) disable iff (reset_i)
        term && !demod && !single && !start |=> running && counter == $past(reload);
    endproperty
    a_reload: assert property (p_reload) else $error("modulo reload wrong"); // [RULE2]

    property p_single;
        @(posedge mclk_i) disable iff (reset_i)
        term && !demod && single && !start |=> !running;
    endproperty
    a_single: assert property (p_single) else $error("single pass kept running"); // [RULE3]

    property p_to_set;
        @(posedge mclk_i) disable iff (reset_i)
        term |=> ctrl_first[ebdt_pkg::CF_TIMEOUT] && irq_status[ebdt_pkg::IRQ_TIMEOUT];
    endproperty
    a_to_set: assert property (p_to_set) else $error("time-out flag not set"); // [RULE4]

    property p_to_hold;
        @(posedge mclk_i) disable iff (reset_i)
        ctrl_first[ebdt_pkg::CF_TIMEOUT] && !(wr_first && wb[ebdt_pkg::CF_TIMEOUT])
        |=> ctrl_first[ebdt_pkg::CF_TIMEOUT];
    endproperty
    a_to_hold: assert property (p_to_hold) else $error("time-out flag lost"); // [RULE4]

    property p_cap_pos;
        @(posedge mclk_i) disable iff (reset_i)
        cap_pos |=> pos_capture == ~$past(counter) && ctrl_second[ebdt_pkg::CS_POS_FLAG];
    endproperty
    a_cap_pos: assert property (p_cap_pos) else $error("positive capture wrong"); // [RULE12]

    property p_cap_neg;
        @(posedge mclk_i) disable iff (reset_i)
        cap_neg |=> neg_capture == ~$past(counter) && ctrl_second[ebdt_pkg::CS_NEG_FLAG];
    endproperty
    a_cap_neg: assert property (p_cap_neg) else $error("negative capture wrong"); // [RULE13]

    property p_cap_reload;
        @(posedge mclk_i) disable iff (reset_i)
        capture && !start |=> counter == ebdt_pkg::DEMOD_RELOAD;
    endproperty
    a_cap_reload: assert property (p_cap_reload) else $error("no reload on capture"); // [RULE14]

    property p_cap_irq;
        @(posedge mclk_i) disable iff (reset_i)
        capture && irq_mask[1] && ctrl_first[ebdt_pkg::CF_CAP_IE] && !wr_first && !wr_mask
        |=> irq_o;
    endproperty
    a_cap_irq: assert property (p_cap_irq) else $error("capture irq missing"); // [RULE8]

    property p_demod_to;
        @(posedge mclk_i) disable iff (reset_i)
        term && demod && !start |=> counter == ebdt_pkg::DEMOD_RELOAD && running;
    endproperty
    a_demod_to: assert property (p_demod_to) else $error("demod time-out wrong"); // [RULE15]

    property p_first_edge;
        @(posedge mclk_i) disable iff (reset_i)
        enable && demod && !running && edge_q && !start |=> running && !capture;
    endproperty
    a_first_edge: assert property (p_first_edge) else $error("first edge no start"); // [RULE10]

    property p_sync;
        @(posedge mclk_i) disable iff (reset_i)
        rise_raw |-> $past(capture_pin_i, 2) && !$past(capture_pin_i, 3);
    endproperty
    a_sync: assert property (p_sync) else $error("double edge event"); // [RULE16]

    c_capture: cover property (@(posedge mclk_i) disable iff (reset_i) cap_pos);
    c_capneg:  cover property (@(posedge mclk_i) disable iff (reset_i) cap_neg);
    c_modulo:  cover property (@(posedge mclk_i) disable iff (reset_i) term && !single);
    c_irq:     cover property (@(posedge mclk_i) disable iff (reset_i) irq_o);
endmodule // ebdt_timer
`default_nettype wire

// [tb/ebdt_pulse_src.sv]
// model of the external pulse source on the capture input
`timescale 1ns/1ps
`default_nettype none
module ebdt_pulse_src (
    input  wire logic mclk_i,
    output var logic  pin_o
);
    initial pin_o = 1'b0;
    // holds a level for a number of system clocks, changed just after an edge
    task automatic drive(input logic lvl, input int cycles);
        @(posedge mclk_i);
        pin_o <= lvl;
        repeat (cycles) @(posedge mclk_i);
    endtask
endmodule // ebdt_pulse_src
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the eight-bit demodulating timer
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ========================================
    // signals and instances
    logic        mclk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rd_data;
    logic        capture_pin_i, irq_o;
    int          miscompares = 0;
    int          comparisons = 0;

    always #2.5 mclk_i = ~mclk_i;

    ebdt_timer dut (.mclk_i, .reset_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .capture_pin_i, .irq_o);
    ebdt_pulse_src src (.mclk_i, .pin_o(capture_pin_i));

    // ========================================
    // reporting and bus tasks
    task automatic stop_test();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic hang(input string msg);
        miscompares++;
        $display("[FAIL] %0t no answer on %s", $time, msg);
        stop_test();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk_i);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge mclk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        resp = s_axi_bresp;
        if (n == 40) hang("write");
    endtask

    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge mclk_i);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge mclk_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        rd_data = s_axi_rdata;
        resp = s_axi_rresp;
        if (n == 40) hang("read");
    endtask

    // ========================================
    // scenarios
    task automatic t_reset();
        rd(ebdt_pkg::OFS_CTRL_FIRST);
        chk(rd_data === {24'h0, ebdt_pkg::RST_CTRL}, "control reset value");
        rd(ebdt_pkg::OFS_INIT_LOW);
        chk(rd_data === {24'h0, ebdt_pkg::RST_INIT}, "initial count reset value");
        chk(irq_o === 1'b0, "interrupt after reset");
        $display("reset test done");
    endtask

    task automatic t_single(input logic [1:0] sel, input int div);
        int n;
        wr(ebdt_pkg::OFS_CTRL_FIRST, 32'h20);
        wr(ebdt_pkg::OFS_IRQ_STATUS, 32'h3);
        wr(ebdt_pkg::OFS_IRQ_MASK, 32'h1);
        wr(ebdt_pkg::OFS_INIT_LOW, 32'h3);
        wr(ebdt_pkg::OFS_CTRL_FIRST, {24'h0, 8'hc2 | {3'h0, sel, 3'h0}});
        for (n = 0; n < 200 && irq_o !== 1'b1; n++) @(posedge mclk_i);
        chk(n >= 2 * div && n <= 5 * div + 8, "time-out delay vs clock select");
        rd(ebdt_pkg::OFS_COUNTER);
        chk(rd_data === 32'h0, "single pass counter at end");
        repeat (2 * div) @(posedge mclk_i);
        rd(ebdt_pkg::OFS_COUNTER);
        chk(rd_data === 32'h0, "single pass counter stays halted");
        wr(ebdt_pkg::OFS_CTRL_FIRST, 32'h42);
        rd(ebdt_pkg::OFS_CTRL_FIRST);
        chk(rd_data[5] === 1'b1, "time-out kept by writing 0");
        wr(ebdt_pkg::OFS_CTRL_FIRST, 32'h20);
        wr(ebdt_pkg::OFS_IRQ_STATUS, 32'h1);
        rd(ebdt_pkg::OFS_CTRL_FIRST);
        chk(rd_data[5] === 1'b0 && irq_o === 1'b0, "time-out cleared by 1");
        $display("single pass test done");
    endtask

    task automatic t_modulo();
        int n;
        wr(ebdt_pkg::OFS_INIT_LOW, 32'h40);
        wr(ebdt_pkg::OFS_INIT_HIGH, 32'h4);
        wr(ebdt_pkg::OFS_CTRL_FIRST, 32'h80);
        for (n = 0; n < 60; n++) begin
            rd(ebdt_pkg::OFS_CTRL_FIRST);
            if (rd_data[5] === 1'b1) break;
        end
        chk(rd_data[5] === 1'b1, "modulo time-out");
        rd(ebdt_pkg::OFS_COUNTER);
        chk(rd_data[7:0] >= 8'h3c && rd_data[7:0] <= 8'h40, "modulo reload value");
        wr(ebdt_pkg::OFS_CTRL_FIRST, 32'h60);
        $display("modulo test done");
    endtask

    task automatic t_demod();
        int n;
        wr(ebdt_pkg::OFS_INIT_LOW, 32'hff);
        wr(ebdt_pkg::OFS_INIT_HIGH, 32'hff);
        wr(ebdt_pkg::OFS_CTRL_SECOND, 32'h63);
        wr(ebdt_pkg::OFS_IRQ_STATUS, 32'h3);
        wr(ebdt_pkg::OFS_IRQ_MASK, 32'h2);
        wr(ebdt_pkg::OFS_CTRL_FIRST, 32'ha4);
        src.drive(1'b1, 40);
        src.drive(1'b0, 60);
        src.drive(1'b1, 10);
        rd(ebdt_pkg::OFS_NEG_CAPTURE);
        chk(rd_data >= 32'd18 && rd_data <= 32'd22, "falling edge capture");
        rd(ebdt_pkg::OFS_POS_CAPTURE);
        chk(rd_data >= 32'd28 && rd_data <= 32'd32, "rising edge capture");
        rd(ebdt_pkg::OFS_CTRL_SECOND);
        chk(rd_data[1:0] === 2'h3 && irq_o === 1'b1, "edge flags and irq");
        wr(ebdt_pkg::OFS_CTRL_SECOND, 32'h62);
        rd(ebdt_pkg::OFS_CTRL_SECOND);
        chk(rd_data[1:0] === 2'h1, "one edge flag cleared");
        wr(ebdt_pkg::OFS_CTRL_SECOND, 32'h61);
        wr(ebdt_pkg::OFS_IRQ_STATUS, 32'h2);
        chk(irq_o === 1'b0, "capture irq cleared");
        for (n = 0; n < 250; n++) begin
            rd(ebdt_pkg::OFS_CTRL_FIRST);
            if (rd_data[5] === 1'b1) break;
        end
        rd(ebdt_pkg::OFS_COUNTER);
        chk(n < 250 && rd_data[7:0] >= 8'hf0, "demodulation time-out wraps");
        wr(ebdt_pkg::OFS_CTRL_SECOND, 32'h53);
        src.drive(1'b0, 10);
        src.drive(1'b1, 10);
        rd(ebdt_pkg::OFS_CTRL_SECOND);
        chk(rd_data[1:0] === 2'h2, "rise-only edge select");
        $display("demodulation test done");
    endtask

    task automatic t_unmapped();
        rd(8'h40);
        chk(resp === ebdt_pkg::AXI_SLVERR && rd_data === 32'h0, "unmapped read");
        wr(8'h40, 32'h1);
        chk(resp === ebdt_pkg::AXI_SLVERR, "unmapped write");
        $display("unmapped test done");
    endtask

    // ========================================
    // main sequence
    initial begin
        repeat (10) @(posedge mclk_i);
        reset_i <= 1'b0;
        t_reset();
        t_single(2'h0, ebdt_pkg::DIV_SEL0);
        t_single(2'h3, ebdt_pkg::DIV_SEL3);
        t_modulo();
        t_demod();
        t_unmapped();
        stop_test();
    end
endmodule // tb
`default_nettype wire
